// file: common/eepw_defines.vh
// Purpose: constants for the page-write EEPROM host controller
// Assumes: ref_clk at 40 MHz (25 ns period)
// Notes: times in their own unit, cycle counts derived from them
`ifndef EEPW_DEFINES_VH
`define EEPW_DEFINES_VH

`define EEPW_CLK_PS 25000
// Strobe low width, well above the 20 ns glitch filter (ns)
`define EEPW_STROBE_NS 350
`define EEPW_STROBE_CYC ((`EEPW_STROBE_NS * 1000 + `EEPW_CLK_PS - 1) / `EEPW_CLK_PS)
// Least byte load spacing, slowest grade (ns)
`define EEPW_BLOAD_MIN_NS 950
`define EEPW_BLOAD_MIN_CYC ((`EEPW_BLOAD_MIN_NS * 1000 + `EEPW_CLK_PS - 1) / `EEPW_CLK_PS)
// Longest byte load spacing (us)
`define EEPW_BLOAD_MAX_US 30
`define EEPW_BLOAD_MAX_CYC ((`EEPW_BLOAD_MAX_US * 1000000) / `EEPW_CLK_PS)
// Write start delay before polling, slowest grade (ns)
`define EEPW_RESTART_NS 250
`define EEPW_RESTART_CYC ((`EEPW_RESTART_NS * 1000 + `EEPW_CLK_PS - 1) / `EEPW_CLK_PS)
// Lock release to first write, slowest grade (us)
`define EEPW_UNLOCK_US 200
`define EEPW_UNLOCK_CYC ((`EEPW_UNLOCK_US * 1000000 + `EEPW_CLK_PS - 1) / `EEPW_CLK_PS)
// Program cycle time (ms)
`define EEPW_PROG_MS 10
// Period converted to ns first, so the product stays inside 32 bits
`define EEPW_PROG_CYC (`EEPW_PROG_MS * 1000000 / (`EEPW_CLK_PS / 1000))

// Command addresses and data
`define EEPW_CMD_A1 17'h05555
`define EEPW_CMD_A2 17'h02aaa
`define EEPW_CMD_D1 8'haa
`define EEPW_CMD_D2 8'h55
`define EEPW_CMD_PROT 8'ha0
`define EEPW_CMD_CAN1 8'h80
`define EEPW_CMD_CAN2 8'h20

// Operation codes
`define EEPW_OP_WRITE 2'h0
`define EEPW_OP_READ 2'h1
`define EEPW_OP_UNPROT 2'h2

`define EEPW_PAGE_BYTES 8'h80
`endif

// file: design/eepw_host.v
// Purpose: host controller driving a byte-wide page-write EEPROM
// Assumes: ref_clk 40 MHz; one operation at a time on the req port
// Notes: write completion by busy pin or top-bit polling, else timeout
// Contract
// RULE_01: a page write carries 1 to 128 bytes sharing upper address bits.
// RULE_02: host loads each next byte within 30 us of the previous.
// RULE_03: strobes idle high 100 us after last byte starts programming.
// RULE_04: device changes only loaded bytes of the page.
// RULE_05: address captured on later falling edge of strobes.
// RULE_06: data captured on earlier rising edge of strobes.
// RULE_07: during programming top data bit reads inverted.
// RULE_08: busy pin floats outside writes, low after first strobe.
// RULE_09: busy pin released when programming ends.
// RULE_10: lock low blocks reads and programming.
// RULE_11: lock low during programming aborts it.
// RULE_12: host holds lock high 10 ms after last byte.
// RULE_13: host holds lock low while power ramps.
// RULE_14: strobe pulses of 20 ns or less are ignored.
// RULE_15: protected writes preceded by AA/5555, 55/2AAA, A0/5555.
// RULE_16: six-write sequence with 80 and 20 cancels protection.
// RULE_17: cancel sequence writes are not stored.
// RULE_18: program finishes within 10 ms; wait that long without status.
// RULE_19: with polling or busy, next access after write start delay.
// RULE_20: byte loads spaced 0.95 us least, 30 us most.
// RULE_21: wait 200 us after raising lock before writing.
// RULE_22: chip enable, output enable, write enable decode bus mode.
// RULE_23: a mismatched write abandons a partial command sequence.
`timescale 1ns/1ps
`include "eepw_defines.vh"
module eepw_host #(
	parameter PROG_CYC = `EEPW_PROG_CYC,
	parameter UNLOCK_CYC = `EEPW_UNLOCK_CYC
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst_b,
	// User request
	input wire req_valid,
	output reg req_ready,
	input wire [1:0] req_op,
	input wire req_protect,
	input wire [16:0] req_addr,
	input wire [7:0] req_len_m1,
	// Write data supply, one byte per take
	input wire [7:0] wr_data,
	output reg wr_take,
	// Read answer, completion pulse and write timeout
	output reg rd_valid,
	output reg [7:0] rd_data,
	output reg done,
	output reg timeout,
	// Memory pins
	output reg [16:0] mem_addr,
	output reg chip_en_n,
	output reg out_en_n,
	output reg write_en_n,
	output reg [7:0] dq_out,
	output reg dq_oe,
	input wire [7:0] dq_in,
	input wire ready_busy_n,
	output reg hardware_lock_n
);
	localparam S_LOCK = 4'h0, S_IDLE = 4'h1, S_CMD = 4'h2, S_DAT = 4'h3;
	localparam S_LOW = 4'h4, S_GAP = 4'h5, S_WAIT = 4'h6, S_POLL = 4'h7;
	localparam S_RLOW = 4'h8, S_RGAP = 4'h9, S_DONE = 4'ha;

	wire [7:0] dq_s;
	wire busy_s;
	reg [3:0] state;
	reg [3:0] after_low;
	reg [31:0] cnt;
	reg [31:0] wcnt;
	reg [2:0] cidx;
	reg [2:0] clen;
	reg [7:0] left;
	reg [6:0] col;
	reg [16:0] base;
	reg [7:0] last_byte;
	reg polling;

	// Pins come from outside the clock domain
	eepw_sync #(.W(9)) u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.din({ready_busy_n, dq_in}),
		.dout({busy_s, dq_s})
	);

	// Command step table: address and data per index
	function [24:0] cmd_word;
		input [2:0] i;
		input cancel;
		begin
			case (i)
			3'h0, 3'h3: cmd_word = {`EEPW_CMD_A1, `EEPW_CMD_D1};
			3'h1, 3'h4: cmd_word = {`EEPW_CMD_A2, `EEPW_CMD_D2};
			3'h2: cmd_word = {`EEPW_CMD_A1,
				cancel ? `EEPW_CMD_CAN1 : `EEPW_CMD_PROT};
			default: cmd_word = {`EEPW_CMD_A1, `EEPW_CMD_CAN2};
			endcase
		end
	endfunction

	// Main sequencer
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			state <= S_LOCK;
			after_low <= S_IDLE;
			cnt <= 32'h0;
			wcnt <= 32'h0;
			cidx <= 3'h0;
			clen <= 3'h0;
			left <= 8'h0;
			col <= 7'h0;
			base <= 17'h0;
			last_byte <= 8'h0;
			polling <= 1'b0;
			req_ready <= 1'b0;
			wr_take <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h0;
			done <= 1'b0;
			timeout <= 1'b0;
			mem_addr <= 17'h0;
			chip_en_n <= 1'b1;
			out_en_n <= 1'b1;
			write_en_n <= 1'b1;
			dq_out <= 8'h0;
			dq_oe <= 1'b0;
			hardware_lock_n <= 1'b0; // Held low through reset [RULE_13]
		end else begin
			wr_take <= 1'b0;
			rd_valid <= 1'b0;
			done <= 1'b0;
			timeout <= 1'b0;
			case (state)
			// Lock released, then settle before any write
			S_LOCK: begin
				hardware_lock_n <= 1'b1; // [RULE_10]
				cnt <= cnt + 32'h1;
				if (cnt >= UNLOCK_CYC) begin // [RULE_21]
					state <= S_IDLE;
					req_ready <= 1'b1;
				end
			end
			S_IDLE: begin
				cnt <= 32'h0;
				// Fresh wait count; a cancel never passes the data path
				wcnt <= 32'h0;
				polling <= 1'b0;
				if (req_valid) begin
					req_ready <= 1'b0;
					base <= req_addr;
					// Page limited to one 128-byte page [RULE_01]
					col <= req_addr[6:0];
					left <= (req_len_m1 > 8'h7f - {1'b0, req_addr[6:0]}) ?
						8'h7f - {1'b0, req_addr[6:0]} : req_len_m1;
					cidx <= 3'h0;
					if (req_op == `EEPW_OP_READ) begin
						state <= S_RLOW;
						mem_addr <= req_addr;
						chip_en_n <= 1'b0; // Read decode [RULE_22]
						out_en_n <= 1'b0;
					end else begin
						// Protect uses 3 commands, cancel 6 [RULE_15] [RULE_16]
						clen <= (req_op == `EEPW_OP_UNPROT) ? 3'h6 :
							(req_protect ? 3'h3 : 3'h0);
						state <= S_CMD;
					end
				end
			end
			// Issue next command word, or move to data, or to the wait after a cancel
			S_CMD: begin
				if (cidx == clen) begin
					state <= (clen == 3'h6) ? S_WAIT : S_DAT;
				end else begin
					{mem_addr, dq_out} <= cmd_word(cidx, clen == 3'h6);
					cidx <= cidx + 3'h1;
					dq_oe <= 1'b1;
					chip_en_n <= 1'b0; // Later falling edge latches address [RULE_05]
					write_en_n <= 1'b0; // Write decode with out_en_n high [RULE_22]
					after_low <= S_CMD;
					cnt <= 32'h0;
					state <= S_LOW;
				end
			end
			// Load next page byte
			S_DAT: begin
				mem_addr <= {base[16:7], col};
				dq_out <= wr_data;
				last_byte <= wr_data;
				wr_take <= 1'b1;
				dq_oe <= 1'b1;
				chip_en_n <= 1'b0;
				write_en_n <= 1'b0;
				after_low <= S_DAT;
				cnt <= 32'h0;
				state <= S_LOW;
			end
			// Strobe low long enough to pass the noise filter [RULE_14]
			S_LOW: begin
				cnt <= cnt + 32'h1;
				if (cnt + 32'h1 >= `EEPW_STROBE_CYC) begin
					write_en_n <= 1'b1; // Earlier rising edge latches data [RULE_06]
					chip_en_n <= 1'b1;
					cnt <= 32'h0;
					state <= S_GAP;
				end
			end
			// Spacing between loads; well inside the 30 us window
			S_GAP: begin
				dq_oe <= 1'b0;
				cnt <= cnt + 32'h1;
				if (cnt + 32'h1 + `EEPW_STROBE_CYC >= `EEPW_BLOAD_MIN_CYC) begin
					cnt <= 32'h0; // [RULE_20] [RULE_02]
					if (after_low == S_CMD)
						state <= S_CMD;
					else if (left == 8'h0) begin
						// Strobes idle now start programming [RULE_03]
						wcnt <= 32'h0;
						polling <= 1'b0;
						state <= S_WAIT;
					end else begin
						left <= left - 8'h1;
						col <= col + 7'h1;
						state <= S_DAT;
					end
				end
			end
			// Wait for programming; lock stays high meanwhile [RULE_12]
			S_WAIT: begin
				wcnt <= wcnt + 32'h1;
				if (wcnt >= PROG_CYC) begin
					// Device bound to finish by now [RULE_18]
					timeout <= !busy_s || polling;
					state <= S_DONE;
				end else if (clen == 3'h6) begin
					// Cancel writes store nothing; just let it settle [RULE_17]
					if (wcnt >= `EEPW_RESTART_CYC)
						state <= S_DONE;
				end else if (wcnt >= `EEPW_RESTART_CYC && busy_s
					&& !polling) begin
					// Busy high again: released [RULE_09] [RULE_19]
					state <= S_DONE;
				end else if (wcnt >= `EEPW_RESTART_CYC && !polling) begin
					polling <= 1'b1;
					chip_en_n <= 1'b0;
					out_en_n <= 1'b0;
					mem_addr <= {base[16:7], col};
					cnt <= 32'h0;
					state <= S_POLL;
				end
			end
			// Poll top data bit until it reads true [RULE_07] [RULE_08]
			S_POLL: begin
				wcnt <= wcnt + 32'h1;
				cnt <= cnt + 32'h1;
				if (cnt >= 32'h4) begin
					cnt <= 32'h0;
					if (dq_s[7] == last_byte[7] || wcnt >= PROG_CYC) begin
						timeout <= dq_s[7] != last_byte[7];
						chip_en_n <= 1'b1;
						out_en_n <= 1'b1;
						state <= S_DONE;
					end
				end
			end
			// Read: hold enables for synchroniser latency plus access
			S_RLOW: begin
				cnt <= cnt + 32'h1;
				if (cnt + 32'h1 >= `EEPW_STROBE_CYC) begin
					rd_data <= dq_s;
					rd_valid <= 1'b1;
					chip_en_n <= 1'b1;
					out_en_n <= 1'b1;
					state <= S_RGAP;
				end
			end
			S_RGAP: begin
				state <= S_DONE;
			end
			S_DONE: begin
				chip_en_n <= 1'b1;
				out_en_n <= 1'b1;
				done <= 1'b1;
				req_ready <= 1'b1;
				state <= S_IDLE;
			end
			default: begin
				state <= S_IDLE;
				req_ready <= 1'b1;
			end
			endcase
		end
	end
endmodule // eepw_host

// file: design/eepw_sync.v
// Purpose: two-flop synchroniser for an asynchronous pin
// Assumes: single clock ref_clk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module eepw_sync #(
	parameter W = 1
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst_b,
	// Data
	input wire [W-1:0] din,
	output reg [W-1:0] dout
);
	reg [W-1:0] meta;

	// Two stages, reset to idle high
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			meta <= {W{1'b1}};
			dout <= {W{1'b1}};
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // eepw_sync

// file: verif/eepw_host_sva.sv
// Purpose: pin timing checks for the host
// Assumes: one clock, rst_b sync active low
// Notes: counters saturate over long idle
`timescale 1ns/1ps
`include "eepw_defines.vh"
module eepw_host_sva #(
	parameter UNLOCK_CYC = 1
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst_b,
	// Memory pins
	input wire [16:0] mem_addr,
	input wire chip_en_n,
	input wire out_en_n,
	input wire write_en_n,
	input wire [7:0] dq_out,
	input wire dq_oe,
	input wire hardware_lock_n
);
	logic [15:0] up_cnt;
	logic [15:0] gap;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Cycles since lock release and since strobe fall
	always @(posedge ref_clk) begin
		if (!hardware_lock_n)
			up_cnt <= 16'h0000;
		else if (up_cnt != 16'hffff)
			up_cnt <= up_cnt + 16'h0001;
		if (!rst_b)
			gap <= 16'hffff;
		else if ($fell(write_en_n))
			gap <= 16'h0000;
		else if (gap != 16'hffff)
			gap <= gap + 16'h0001;
	end
	sequence s_held;
		!write_en_n [*8];
	endsequence
	a_read_mode: assert property (!out_en_n |->
		!chip_en_n && write_en_n && !dq_oe) else $error("bad read pins");
	a_write_mode: assert property (!write_en_n |->
		!chip_en_n && out_en_n && dq_oe && hardware_lock_n)
		else $error("bad write pins");
	a_strobe_wide: assert property ($fell(write_en_n) |-> s_held)
		else $error("strobe too short");
	a_pins_stable: assert property (!write_en_n && $past(!write_en_n)
		|-> $stable(mem_addr) && $stable(dq_out)) else $error("pins moved");
	a_unlock_wait: assert property ($fell(write_en_n)
		|-> up_cnt >= UNLOCK_CYC) else $error("write too soon");
	a_load_space: assert property ($fell(write_en_n)
		|-> gap >= `EEPW_BLOAD_MIN_CYC - 1) else $error("loads too close");
	a_lock_hold: assert property (!$fell(hardware_lock_n))
		else $error("lock dropped");
	a_restart_gap: assert property ($rose(write_en_n)
		|-> out_en_n [*8]) else $error("read too soon");
endmodule // eepw_host_sva
bind eepw_host eepw_host_sva #(.UNLOCK_CYC(UNLOCK_CYC)) eepw_host_sva_inst (
	.ref_clk(ref_clk), .rst_b(rst_b), .mem_addr(mem_addr),
	.chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
	.dq_out(dq_out), .dq_oe(dq_oe), .hardware_lock_n(hardware_lock_n));

// file: verif/eepw_mem_model.sv
// Purpose: page-write memory seen by the host
// Assumes: pins sampled on ref_clk
// Notes: busy_low pulls the open-drain pin
`timescale 1ns/1ps
module eepw_mem_model #(
	parameter WIN = 100,
	parameter PROG = 300
) (
	// Clock and speed
	input wire ref_clk,
	input wire slow,
	// Memory pins
	input wire [16:0] mem_addr,
	input wire chip_en_n,
	input wire out_en_n,
	input wire write_en_n,
	input wire [7:0] dq_out,
	input wire hardware_lock_n,
	output logic [7:0] dq_in,
	output wire busy_low
);
	logic [7:0] mem [0:131071];
	logic [7:0] pg [0:127];
	logic [127:0] ld = '0;
	logic [16:0] la;
	logic [9:0] pa;
	logic [7:0] d;
	logic [7:0] last = 8'h00;
	logic wr_q = 0;
	logic prot = 0;
	logic arm = 0;
	int tmr = 0;
	int busy = 0;
	int k = 0;
	wire wr = !chip_en_n && !write_en_n && out_en_n;
	wire go = k == 2 && d == 8'ha0;
	assign busy_low = hardware_lock_n && (ld != '0 || busy != 0);
	initial for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
	initial dq_in = 8'h00;
	// Does the latched write match command step k
	function automatic logic hit(int k, logic [16:0] a, logic [7:0] d);
		logic ok;
		ok = (k % 3 == 1) ? (a == 17'h02aaa || a == 17'h0aaaa) : a == 17'h05555;
		case (k)
			0, 3: hit = ok && d == 8'haa;
			1, 4: hit = ok && d == 8'h55;
			2: hit = ok && (d == 8'ha0 || d == 8'h80);
			default: hit = ok && d == 8'h20;
		endcase
	endfunction
	// Strobe latching, load window and programming
	always @(posedge ref_clk) begin
		wr_q <= wr; // Pulses under one sample never seen
		if (wr) d <= dq_out;
		if (wr && !wr_q) la <= mem_addr;
		if (busy != 0) busy <= busy - 1;
		if (!hardware_lock_n) begin
			ld <= '0;
			busy <= 0;
			k <= 0;
			arm <= 0;
		end else if (!wr && wr_q) begin
			if (ld == '0 && hit(k, la, d)) begin
				k <= (go || k == 5) ? 0 : k + 1;
				if (go) arm <= 1'b1;
				if (go) prot <= 1'b1;
				if (k == 5) prot <= 1'b0;
			end else begin
				k <= 0;
				if (!prot || arm) begin
					pg[la[6:0]] <= d;
					ld[la[6:0]] <= 1'b1;
					pa <= la[16:7];
					last <= d;
					tmr <= 0;
				end
			end
		end else if (ld != '0 && busy == 0) begin
			tmr <= tmr + 1;
			if (tmr == WIN) busy <= slow ? 3 * PROG : PROG;
		end
		if (busy == 1 && hardware_lock_n) begin
			for (int i = 0; i < 128; i++) if (ld[i]) mem[{pa, i[6:0]}] <= pg[i];
			ld <= '0;
			arm <= 0;
		end
	end
	// Reads; a floating bus keeps toggling
	always @(posedge ref_clk) begin
		if (!chip_en_n && !out_en_n && write_en_n && hardware_lock_n)
			dq_in <= busy_low ? {~last[7], ~dq_in[6:0]} : mem[mem_addr];
		else
			dq_in <= ~dq_in;
	end
endmodule // eepw_mem_model

// file: verif/test_eepw_host.sv
// Purpose: self-checking bench for the host
// Assumes: short program and unlock counts
// Notes: expected image kept here
`timescale 1ns/1ps
module test_eepw_host;
	logic ref_clk = 0, rst_b = 0, req_valid = 0, req_protect = 0, slow = 0;
	logic [1:0] req_op = 0;
	logic [16:0] req_addr = 0, a;
	logic [7:0] req_len_m1 = 0, wr_data = 0, rd_got;
	wire req_ready, wr_take, rd_valid, done, timeout, ce_n, oe_n, we_n;
	wire dq_oe, busy_low, hardware_lock_n;
	wire [7:0] rd_data, dq_out, dq_mem;
	wire [16:0] mem_addr;
	logic [7:0] exp_mem [0:131071];
	logic [7:0] bytes [0:128];
	int err_total = 0, num_checks = 0, cyc = 0, bi = 0, seed = 32'hd6d3;
	eepw_host #(.PROG_CYC(2000), .UNLOCK_CYC(20)) eepw_host_inst (
		.ref_clk(ref_clk), .rst_b(rst_b), .req_valid(req_valid),
		.req_ready(req_ready), .req_op(req_op), .req_protect(req_protect),
		.req_addr(req_addr), .req_len_m1(req_len_m1), .wr_data(wr_data),
		.wr_take(wr_take), .rd_valid(rd_valid), .rd_data(rd_data),
		.done(done), .timeout(timeout), .mem_addr(mem_addr),
		.chip_en_n(ce_n), .out_en_n(oe_n), .write_en_n(we_n),
		.dq_out(dq_out), .dq_oe(dq_oe),
		.dq_in(dq_oe ? dq_out : dq_mem), .ready_busy_n(!busy_low),
		.hardware_lock_n(hardware_lock_n));
	eepw_mem_model eepw_mem_model_inst (.ref_clk(ref_clk), .slow(slow),
		.mem_addr(mem_addr), .chip_en_n(ce_n), .out_en_n(oe_n),
		.write_en_n(we_n), .dq_out(dq_out), .hardware_lock_n(hardware_lock_n),
		.dq_in(dq_mem), .busy_low(busy_low));
	always #12.5 ref_clk = ~ref_clk;
	// Hang guard and byte supply
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_total++;
			finish_test;
		end
		if (wr_take === 1'b1) begin
			bi <= bi + 1;
			wr_data <= bytes[bi + 1];
		end
	end
	always @(negedge ref_clk) if (rd_valid === 1'b1) rd_got = rd_data;
	task check(input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask
	// Bytes a page write really stores, clipped at page end
	function automatic int fn_cnt(logic [16:0] a, logic [7:0] m);
		return (m + 1 > 128 - a[6:0]) ? 128 - a[6:0] : m + 1;
	endfunction
	task automatic run(logic [1:0] op, logic p, logic [16:0] a, logic [7:0] m);
		int n = 0;
		while (req_ready !== 1'b1 && n < 8000) begin
			@(negedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
		req_op <= op;
		req_protect <= p;
		req_addr <= a;
		req_len_m1 <= m;
		req_valid <= 1;
		@(posedge ref_clk);
		req_valid <= 0;
		while (done !== 1'b1 && n < 16000) begin
			@(negedge ref_clk);
			n++;
		end
		check({7'h00, timeout}, 8'h00);
	endtask
	task automatic wr_page(logic p, logic [16:0] a, logic [7:0] m, logic ok);
		for (int i = 0; i < 129; i++) bytes[i] = $random(seed);
		bi <= 0;
		wr_data <= bytes[0];
		run(2'h0, p, a, m);
		if (ok) for (int i = 0; i < fn_cnt(a, m); i++) exp_mem[a + i] = bytes[i];
	endtask
	task automatic rd_chk(logic [16:0] a);
		run(2'h1, 1'b0, a, 8'h00);
		check(rd_got, exp_mem[a]);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 131072; i++) exp_mem[i] = 8'hff;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1;
		wr_page(0, 17'h00100, 8'h7f, 1);
		rd_chk(17'h0017f);
		wr_page(0, 17'h00a7c, 8'h0f, 1);
		rd_chk(17'h00a7f);
		rd_chk(17'h00a80);
		for (int j = 0; j < 4; j++) begin
			a = $random(seed);
			slow <= j[0];
			wr_page(0, a, 8'($random(seed)), 1);
			rd_chk(a);
			rd_chk({a[16:7], 7'h7f});
		end
		slow <= 0;
		wr_page(1, 17'h01234, 8'h03, 1);
		rd_chk(17'h01236);
		wr_page(0, 17'h01300, 8'h00, 0);
		rd_chk(17'h01300);
		run(2'h2, 1'b0, 17'h00000, 8'h00);
		rd_chk(17'h05555);
		wr_page(0, 17'h01300, 8'h00, 1);
		rd_chk(17'h01300);
		bi <= 0;
		wr_data <= 8'h5a;
		@(posedge ref_clk);
		req_op <= 2'h0;
		req_protect <= 1'b0;
		req_addr <= 17'h01400;
		req_len_m1 <= 8'h00;
		req_valid <= 1;
		@(posedge ref_clk);
		req_valid <= 0;
		// Reset lands inside programming; lock drops and aborts it
		repeat (250) @(posedge ref_clk);
		rst_b <= 0;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1;
		rd_chk(17'h01400);
		finish_test;
	end
endmodule // test_eepw_host
